// *** hw/tsac_pkg.sv ***
// constants, types and register map of the temperature alert controller
package tsac_pkg;

    // clock and derived cycle counts
    localparam int CLK_HZ = 40_000_000;
    localparam int CYC_PER_MS = CLK_HZ / 1000;
    localparam int RATE0_MS = 4000;
    localparam int RATE1_MS = 1000;
    localparam int RATE2_MS = 250;
    localparam int RATE3_MS = 125;
    localparam int CONV_MAX_MS = 51;
    localparam int SLEEP_ENTER_MS = 120;
    localparam logic [27:0] RATE0_CYC = 28'(RATE0_MS * CYC_PER_MS);
    localparam logic [27:0] RATE1_CYC = 28'(RATE1_MS * CYC_PER_MS);
    localparam logic [27:0] RATE2_CYC = 28'(RATE2_MS * CYC_PER_MS);
    localparam logic [27:0] RATE3_CYC = 28'(RATE3_MS * CYC_PER_MS);
    localparam logic [27:0] CONV_MAX_CYC = 28'(CONV_MAX_MS * CYC_PER_MS);
    localparam logic [27:0] SLEEP_ENTER_CYC = 28'(SLEEP_ENTER_MS * CYC_PER_MS);

    // register index values
    localparam logic [1:0] ADDR_READING = 2'h0;
    localparam logic [1:0] ADDR_CONFIG = 2'h1;
    localparam logic [1:0] ADDR_LOWER = 2'h2;
    localparam logic [1:0] ADDR_UPPER = 2'h3;

    // configuration field positions
    localparam int CFG_SHOT_BIT = 15;
    localparam int CFG_RSV14_BIT = 14;
    localparam int CFG_FAULT_LSB = 11;
    localparam int CFG_SENSE_BIT = 10;
    localparam int CFG_TRIG_BIT = 9;
    localparam int CFG_SLEEP_BIT = 8;
    localparam int CFG_RATE_LSB = 6;
    localparam int CFG_FLAG_BIT = 5;

    // reset values and masks
    localparam logic [1:0] RATE_RST = 2'h2;
    localparam logic [15:0] LOWER_RST = 16'h2580;
    localparam logic [15:0] UPPER_RST = 16'h2800;
    localparam logic [15:0] LIM_MASK = 16'hFFF0;

    // writable configuration fields
    typedef struct packed {
        logic sleep;
        logic trig;
        logic sense;
        logic [1:0] fault_sel;
        logic [1:0] rate;
    } tsac_cfg_t;

    localparam tsac_cfg_t CFG_RST = '{sleep: 1'b0, trig: 1'b0, sense: 1'b0,
                                      fault_sel: 2'h0, rate: RATE_RST};

    // conversion scheduler states
    typedef enum logic [1:0] {
        ST_BOOT = 2'b11,
        ST_CONVERT = 2'b01,
        ST_STANDBY = 2'b00,
        ST_SLEEP = 2'b10
    } tsac_state_t;

endpackage : tsac_pkg

// *** hw/tsac_fault_cnt.sv ***
// consecutive-fault run counter
`timescale 1ns/1ps
`default_nettype none
module tsac_fault_cnt (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rstn,
    // one conversion result and its fault test
    input wire logic sample,
    input wire logic cond,
    input wire logic [1:0] need_sel,
    input wire logic restart,
    // run complete
    output logic hit
);
    logic [1:0] cnt_q;

    // run is complete when this sample is fault number need_sel+1
    assign hit = sample && cond && (cnt_q == need_sel);

    // count an unbroken run, drop to zero on any break
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            cnt_q <= 2'h0;
        end else if (restart) begin
            cnt_q <= 2'h0;
        end else if (sample) begin
            if (!cond || hit) begin
                cnt_q <= 2'h0;
            end else begin
                cnt_q <= cnt_q + 2'h1;
            end
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);

    property p_run_break;
        sample && !cond && !restart |=> cnt_q == 2'h0;
    endproperty
    a_run_break: assert property (p_run_break) else $error("run not broken");

    property p_run_step;
        sample && cond && !restart && (cnt_q != need_sel) |=> cnt_q == $past(cnt_q) + 2'h1;
    endproperty
    a_run_step: assert property (p_run_step) else $error("run count wrong");

endmodule : tsac_fault_cnt
`default_nettype wire

// *** hw/tsac_top.sv ***
// conversion scheduling, limit registers and alert logic of the sensor
//
// Notes on behaviour
// - configuration is one 16-bit word, moved upper byte then lower byte
// - configuration bits 4..0 and 14..13 are read-only, writes ignored
// - with sense 0 flag reads 1, drops after N highs, returns after N lows
// - output_sense picks active level of pin and flag: 0 low, 1 high
// - in comparator mode the alert pin follows the flag one clock later
// - sample_rate_sel bits 7..6 give 0.25, 1, 4 or 8 conversions per second
// - rate selection resets to four conversions per second
// - a conversion starts right after reset, result due within 51 ms
// - reading updates only at conversion end, standby in between
// - setting sleep_ctl stops continuous conversions at once, registers stay open
// - sleep settles within 120 ms, host pairs sleep with a one-shot
// - clearing sleep_ctl resumes continuous conversion at the selected rate
// - trigger_style 0 is comparator mode, 1 is interrupt mode
// - fault_count_sel needs 1, 2, 3 or 4 consecutive faulting conversions
// - one_shot in sleep runs one conversion, reads 1 meanwhile, then sleep
// - comparator: assert at reading >= upper N times, release at <= lower N times
// - interrupt: assert at reading >= upper N times, hold until any read
// - interrupt: setting sleep_ctl also clears the alert
// - interrupt: after a clear next alert is a low crossing, alternating
// - limits share reading format, bits 3..0 read 0
// - lower limit resets to 16'h2580, upper limit to 16'h2800
// - values are signed 16-bit, one step is 1/128 degree
`timescale 1ns/1ps
`default_nettype none
module tsac_top #(
    parameter logic [27:0] RATE0_CYC = tsac_pkg::RATE0_CYC,
    parameter logic [27:0] RATE1_CYC = tsac_pkg::RATE1_CYC,
    parameter logic [27:0] RATE2_CYC = tsac_pkg::RATE2_CYC,
    parameter logic [27:0] RATE3_CYC = tsac_pkg::RATE3_CYC,
    parameter logic [27:0] CONV_MAX_CYC = tsac_pkg::CONV_MAX_CYC,
    parameter logic [27:0] SLEEP_ENTER_CYC = tsac_pkg::SLEEP_ENTER_CYC
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rstn,
    // byte port from the serial interface front end
    input wire logic xfer_start,
    input wire logic [1:0] reg_sel,
    input wire logic wr_valid,
    input wire logic [7:0] wr_byte,
    input wire logic rd_req,
    output logic [7:0] rd_byte_q,
    output logic rd_valid_q,
    // conversion path
    output logic conv_start_q,
    input wire logic conv_done,
    input wire logic [15:0] conv_result,
    // alert pin and power status
    output logic alert_q,
    output logic deep_sleep_q
);
    import tsac_pkg::*;

    logic phase_q, one_shot_q;
    logic [7:0] hi_byte_q;
    logic [15:0] rd_word_q, lower_q, upper_q, reading_q;
    tsac_cfg_t cfg_q;
    tsac_state_t state_q;
    logic [27:0] cnt_q, period_w;
    logic cmp_active_q, int_active_q, int_arm_hi_q;
    logic wr_commit_w, cfg_wr_w, sleep_set_w, mode_off_w, int_clear_w, shot_req_w;
    logic done_w, sample_w, cmp_cond_w, int_cond_w, cmp_hit_w, int_hit_w, flag_w;
    logic [15:0] wr_word_w, cfg_rd_w, rd_mux_w;

    // write assembly and decoded write side effects
    assign wr_word_w = {hi_byte_q, wr_byte};
    assign wr_commit_w = wr_valid && phase_q;
    assign cfg_wr_w = wr_commit_w && (reg_sel == ADDR_CONFIG);
    assign sleep_set_w = cfg_wr_w && wr_word_w[CFG_SLEEP_BIT] && !cfg_q.sleep;
    assign mode_off_w = cfg_wr_w && !wr_word_w[CFG_TRIG_BIT];
    assign int_clear_w = (rd_req && !phase_q) || (sleep_set_w && cfg_q.trig);
    assign shot_req_w = cfg_wr_w && wr_word_w[CFG_SHOT_BIT] && wr_word_w[CFG_SLEEP_BIT];

    // conversion end: a result, or the longest conversion time ran out
    assign done_w = (state_q == ST_CONVERT) && (conv_done || (cnt_q >= CONV_MAX_CYC));
    assign sample_w = (state_q == ST_CONVERT) && conv_done;
    // signed limit tests on the fresh result
    assign cmp_cond_w = cmp_active_q ? ($signed(conv_result) <= $signed(lower_q))
                                     : ($signed(conv_result) >= $signed(upper_q));
    assign int_cond_w = int_arm_hi_q ? ($signed(conv_result) >= $signed(upper_q))
                                     : ($signed(conv_result) < $signed(lower_q));
    // readable alert flag follows the comparator state in the selected sense
    assign flag_w = cfg_q.sense ? cmp_active_q : !cmp_active_q;
    // conversion period from the rate field
    always_comb begin
        case (cfg_q.rate)
            2'h0: period_w = RATE0_CYC;
            2'h1: period_w = RATE1_CYC;
            2'h2: period_w = RATE2_CYC;
            default: period_w = RATE3_CYC;
        endcase
    end

    // configuration read word, reserved bits fixed
    always_comb begin
        cfg_rd_w = 16'h0000;
        cfg_rd_w[CFG_SHOT_BIT] = one_shot_q;
        cfg_rd_w[CFG_RSV14_BIT] = 1'b1;
        cfg_rd_w[CFG_FAULT_LSB +: 2] = cfg_q.fault_sel;
        cfg_rd_w[CFG_SENSE_BIT] = cfg_q.sense;
        cfg_rd_w[CFG_TRIG_BIT] = cfg_q.trig;
        cfg_rd_w[CFG_SLEEP_BIT] = cfg_q.sleep;
        cfg_rd_w[CFG_RATE_LSB +: 2] = cfg_q.rate;
        cfg_rd_w[CFG_FLAG_BIT] = flag_w;
    end
    // register read select
    always_comb begin
        if (reg_sel == ADDR_READING) begin
            rd_mux_w = reading_q;
        end else if (reg_sel == ADDR_CONFIG) begin
            rd_mux_w = cfg_rd_w;
        end else if (reg_sel == ADDR_LOWER) begin
            rd_mux_w = lower_q;
        end else begin
            rd_mux_w = upper_q;
        end
    end

    // byte sequencing: upper byte first, read word captured once per pair
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            phase_q <= 1'b0;
            hi_byte_q <= 8'h00;
            rd_word_q <= 16'h0000;
            rd_byte_q <= 8'h00;
            rd_valid_q <= 1'b0;
        end else begin
            rd_valid_q <= rd_req;
            if (xfer_start) begin
                phase_q <= 1'b0;
            end else if (wr_valid || rd_req) begin
                phase_q <= !phase_q;
            end
            if (wr_valid && !phase_q && !xfer_start) begin
                hi_byte_q <= wr_byte;
            end
            if (rd_req && !phase_q) begin
                rd_word_q <= rd_mux_w;
                rd_byte_q <= rd_mux_w[15:8];
            end else if (rd_req) begin
                rd_byte_q <= rd_word_q[7:0];
            end
        end
    end

    // configuration fields
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            cfg_q <= CFG_RST;
        end else if (cfg_wr_w) begin
            cfg_q.sleep <= wr_word_w[CFG_SLEEP_BIT];
            cfg_q.trig <= wr_word_w[CFG_TRIG_BIT];
            cfg_q.sense <= wr_word_w[CFG_SENSE_BIT];
            cfg_q.fault_sel <= wr_word_w[CFG_FAULT_LSB +: 2];
            cfg_q.rate <= wr_word_w[CFG_RATE_LSB +: 2];
        end
    end

    // limit registers, low nibble held at zero
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            lower_q <= LOWER_RST;
            upper_q <= UPPER_RST;
        end else if (wr_commit_w && (reg_sel == ADDR_LOWER)) begin
            lower_q <= wr_word_w & LIM_MASK;
        end else if (wr_commit_w && (reg_sel == ADDR_UPPER)) begin
            upper_q <= wr_word_w & LIM_MASK;
        end
    end

    // one-shot request, a new request wins over the end of the last one
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            one_shot_q <= 1'b0;
        end else if (shot_req_w) begin
            one_shot_q <= 1'b1;
        end else if (done_w) begin
            one_shot_q <= 1'b0;
        end
    end

    // conversion scheduler, counter runs from each conversion start
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            state_q <= ST_BOOT;
            cnt_q <= 28'h0000000;
            conv_start_q <= 1'b0;
        end else begin
            conv_start_q <= 1'b0;
            if (cnt_q != 28'hFFFFFFF) begin
                cnt_q <= cnt_q + 28'h0000001;
            end
            case (state_q)
                ST_BOOT: begin
                    state_q <= ST_CONVERT;
                    cnt_q <= 28'h0000000;
                    conv_start_q <= 1'b1;
                end
                ST_CONVERT: begin
                    if (cfg_q.sleep && !one_shot_q) begin
                        state_q <= ST_SLEEP;
                        cnt_q <= 28'h0000000;
                    end else if (done_w) begin
                        state_q <= cfg_q.sleep ? ST_SLEEP : ST_STANDBY;
                        if (cfg_q.sleep) begin
                            cnt_q <= 28'h0000000;
                        end
                    end
                end
                ST_STANDBY: begin
                    if (cfg_q.sleep) begin
                        state_q <= ST_SLEEP;
                        cnt_q <= 28'h0000000;
                    end else if (cnt_q >= period_w - 28'h0000001) begin
                        state_q <= ST_CONVERT;
                        cnt_q <= 28'h0000000;
                        conv_start_q <= 1'b1;
                    end
                end
                ST_SLEEP: begin
                    if (one_shot_q || !cfg_q.sleep) begin
                        state_q <= ST_CONVERT;
                        cnt_q <= 28'h0000000;
                        conv_start_q <= 1'b1;
                    end
                end
                default: begin
                    state_q <= ST_BOOT;
                end
            endcase
        end
    end
    // power status: sleep counted as settled after the entry time
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            deep_sleep_q <= 1'b0;
        end else begin
            deep_sleep_q <= (state_q == ST_SLEEP) && (cnt_q >= SLEEP_ENTER_CYC);
        end
    end
    // result register, zero until the first conversion ends
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            reading_q <= 16'h0000;
        end else if (sample_w) begin
            reading_q <= conv_result;
        end
    end

    // consecutive-fault runs for comparator and interrupt paths
    tsac_fault_cnt u_cmp_run (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .sample(sample_w),
        .cond(cmp_cond_w),
        .need_sel(cfg_q.fault_sel),
        .restart(1'b0),
        .hit(cmp_hit_w)
    );

    tsac_fault_cnt u_int_run (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .sample(sample_w && !int_active_q),
        .cond(int_cond_w),
        .need_sel(cfg_q.fault_sel),
        .restart(!cfg_q.trig),
        .hit(int_hit_w)
    );

    // comparator state toggles at the end of each run
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            cmp_active_q <= 1'b0;
        end else if (cmp_hit_w) begin
            cmp_active_q <= !cmp_active_q;
        end
    end

    // interrupt state: set wins over a clear in the same cycle
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            int_active_q <= 1'b0;
            int_arm_hi_q <= 1'b1;
        end else if (!cfg_q.trig || mode_off_w) begin
            int_active_q <= 1'b0;
            int_arm_hi_q <= 1'b1;
        end else if (int_hit_w) begin
            int_active_q <= 1'b1;
            int_arm_hi_q <= !int_arm_hi_q;
        end else if (int_clear_w) begin
            int_active_q <= 1'b0;
        end
    end

    // alert pin: mode selects the source, sense the level
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            alert_q <= 1'b1;
        end else if (cfg_q.trig) begin
            alert_q <= cfg_q.sense ? int_active_q : !int_active_q;
        end else begin
            alert_q <= flag_w;
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    property p_flag_pin;
        !cfg_q.trig && $stable(cfg_q) && $stable(cmp_active_q) |-> alert_q == flag_w;
    endproperty
    a_flag_pin: assert property (p_flag_pin) else $error("flag differs from pin");
    property p_int_level;
        cfg_q.trig && $stable(cfg_q) && $stable(int_active_q)
            |-> alert_q == (cfg_q.sense ? int_active_q : !int_active_q);
    endproperty
    a_int_level: assert property (p_int_level) else $error("alert level wrong");
    property p_reset_vals;
        $rose(rstn) |-> cfg_q.rate == 2'h2 && lower_q == 16'h2580 && upper_q == 16'h2800;
    endproperty
    a_reset_vals: assert property (p_reset_vals) else $error("bad reset values");
    property p_lim_nibble;
        lower_q[3:0] == 4'h0 && upper_q[3:0] == 4'h0;
    endproperty
    a_lim_nibble: assert property (p_lim_nibble) else $error("limit low bits set");
    property p_cfg_fixed;
        cfg_rd_w[4:0] == 5'h00 && cfg_rd_w[14:13] == 2'b10;
    endproperty
    a_cfg_fixed: assert property (p_cfg_fixed) else $error("reserved bits wrong");
    property p_sleep_hold;
        state_q == ST_SLEEP && cfg_q.sleep && !one_shot_q |=> state_q == ST_SLEEP;
    endproperty
    a_sleep_hold: assert property (p_sleep_hold) else $error("converted in sleep");
    property p_shot_end;
        $fell(one_shot_q) |-> $past(state_q) == ST_CONVERT;
    endproperty
    a_shot_end: assert property (p_shot_end) else $error("one-shot ended early");
    property p_reading_upd;
        !$stable(reading_q) |-> $past(state_q) == ST_CONVERT && $past(conv_done);
    endproperty
    a_reading_upd: assert property (p_reading_upd) else $error("reading changed");
    property p_int_clear;
        $fell(int_active_q) |-> $past(int_clear_w || mode_off_w || !cfg_q.trig);
    endproperty
    a_int_clear: assert property (p_int_clear) else $error("alert cleared early");
    property p_cmp_rise;
        $rose(cmp_active_q) |-> $past(sample_w && $signed(conv_result) >= $signed(upper_q));
    endproperty
    a_cmp_rise: assert property (p_cmp_rise) else $error("comparator set wrongly");
    property p_conv_bound;
        state_q == ST_CONVERT |-> cnt_q <= CONV_MAX_CYC;
    endproperty
    a_conv_bound: assert property (p_conv_bound) else $error("conversion overran");
    property p_boot_start;
        $rose(rstn) |=> conv_start_q && state_q == ST_CONVERT;
    endproperty
    a_boot_start: assert property (p_boot_start) else $error("no start at boot");

endmodule : tsac_top
`default_nettype wire

// *** tb/tsac_conv_model.sv ***
// stand-in for the analog conversion path
`timescale 1ns/1ps
`default_nettype none
module tsac_conv_model (
    // clock
    input wire logic ref_clk,
    // conversion handshake
    input wire logic conv_start_q,
    output logic conv_done,
    output logic [15:0] conv_result,
    // bench controls: answer late or early, value to return
    input wire logic slow,
    input wire logic [15:0] next_res
);
    int cnt = -1;
    initial begin
        conv_done = 1'b0;
        conv_result = 16'h0000;
    end
    // count down after each start, then hand back one result
    always @(negedge ref_clk) begin
        conv_done <= 1'b0;
        conv_result <= ~conv_result; // no stale value outside the result cycle
        if (conv_start_q) begin
            cnt <= slow ? 35 : 3;
        end else if (cnt == 0) begin
            conv_done <= 1'b1;
            conv_result <= next_res;
            cnt <= -1;
        end else if (cnt > 0) begin
            cnt <= cnt - 1;
        end
    end
endmodule : tsac_conv_model
`default_nettype wire

// *** tb/tb.sv ***
// self-checking bench of the temperature alert controller
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic ref_clk, rstn, xfer_start, wr_valid, rd_req, conv_done, slow;
    logic rd_valid_q, conv_start_q, alert_q, deep_sleep_q;
    logic [1:0] reg_sel;
    logic [7:0] wr_byte, rd_byte_q;
    logic [15:0] conv_result, next_res, rnd, v;
    int n_mismatch = 0;
    int checks_done = 0;
    int n;
    int per[4] = '{'h190, 'hC8, 'h64, 'h32};
    // shortened counts keep the run brief
    tsac_top #(.RATE0_CYC(28'h190), .RATE1_CYC(28'hC8), .RATE2_CYC(28'h64),
        .RATE3_CYC(28'h32), .SLEEP_ENTER_CYC(28'h1E)) tsac_top_i (
        .ref_clk, .rstn, .xfer_start, .reg_sel, .wr_valid, .wr_byte, .rd_req,
        .rd_byte_q, .rd_valid_q, .conv_start_q, .conv_done, .conv_result,
        .alert_q, .deep_sleep_q);
    tsac_conv_model tsac_conv_model_i (.ref_clk, .conv_start_q, .conv_done,
        .conv_result, .slow, .next_res);
    // 40 MHz clock
    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end
    // random source and expected-value helpers
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {1'b0, s[15:1]} ^ (s[0] ? 16'hB400 : 16'h0000);
    endfunction : lfsr
    function automatic logic [15:0] hi(input int i);
        rnd = lfsr(rnd);
        return (i == 0) ? 16'h2000 : {3'h1, rnd[12:0]};
    endfunction : hi
    function automatic logic [15:0] lo();
        rnd = lfsr(rnd);
        return {1'b1, rnd[14:0]};
    endfunction : lo
    task automatic cyc(input int k);
        repeat (k) @(negedge ref_clk);
    endtask : cyc
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        checks_done++;
        if (g !== e) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic wr(input logic [1:0] s, input logic [15:0] d);
        cyc(1);
        reg_sel = s;
        xfer_start = 1'b1;
        cyc(1);
        xfer_start = 1'b0;
        wr_valid = 1'b1;
        wr_byte = d[15:8];
        cyc(1);
        wr_byte = d[7:0];
        cyc(1);
        wr_valid = 1'b0;
    endtask : wr
    task automatic rchk(input string nm, input logic [1:0] s, input logic [15:0] e);
        cyc(1);
        reg_sel = s;
        xfer_start = 1'b1;
        cyc(1);
        xfer_start = 1'b0;
        for (int i = 1; i >= 0; i--) begin
            rd_req = 1'b1;
            cyc(1);
            rd_req = 1'b0;
            v[i*8 +: 8] = rd_byte_q;
            chk("rd_valid", 16'h1, {15'h0, rd_valid_q});
            cyc(1);
        end
        chk(nm, e, v);
    endtask : rchk
    task automatic achk(input string nm, input logic e);
        cyc(3);
        chk(nm, {15'h0, e}, {15'h0, alert_q});
    endtask : achk
    task automatic conv(input logic [15:0] r);
        next_res = r;
        n = 0;
        do begin
            cyc(1);
            n++;
        end while (conv_done !== 1'b1 && n < 2000);
        if (n >= 2000) chk("conv_done", 16'h1, 16'h0);
        cyc(4);
    endtask : conv
    task automatic wst();
        n = 0;
        do begin
            cyc(1);
            n++;
        end while (conv_start_q !== 1'b1 && n < 1000);
    endtask : wst
    task automatic final_report();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : final_report
    // main sequence
    initial begin
        {rstn, xfer_start, reg_sel, wr_valid, wr_byte, rd_req} = '0;
        slow = 1'b1;
        next_res = 16'h1800;
        rnd = 16'h80C1;
        cyc(8);
        rstn = 1'b1;
        wst();
        chk("first start", 16'h1, 16'(n < 4));
        rchk("reading rst", 2'h0, 16'h0000);
        rchk("cfg rst", 2'h1, 16'h40A0);
        rchk("lower rst", 2'h2, 16'h2580);
        rchk("upper rst", 2'h3, 16'h2800);
        $display("test reset done");
        slow = 1'b0;
        wr(2'h1, 16'hE01F);
        rchk("cfg ro", 2'h1, 16'h4020);
        cyc(40);
        wr(2'h0, 16'h1234);
        rchk("reading ro", 2'h0, 16'h1800);
        for (int i = 0; i < 4; i++) begin
            rnd = lfsr(rnd);
            wr(2'(2 + i % 2), rnd);
            rchk("limit", 2'(2 + i % 2), rnd & 16'hFFF0);
        end
        wr(2'h2, 16'h1000);
        wr(2'h3, 16'h2000);
        $display("test registers done");
        for (int k = 0; k < 4; k++) begin
            wr(2'h1, 16'h00C0 | 16'(k << 11));
            conv(16'h1800);
            for (int i = 0; i < k; i++) conv(hi(i));
            conv(16'h1800);
            for (int i = 0; i < k; i++) conv(hi(i));
            achk("broken run", 1'b1);
            conv(hi(1));
            achk("cmp set", 1'b0);
            rchk("flag set", 2'h1, 16'h40C0 | 16'(k << 11));
            for (int i = 0; i < k; i++) conv(lo());
            achk("cmp held", 1'b0);
            conv(16'h1000);
            achk("cmp clear", 1'b1);
            rchk("flag clear", 2'h1, 16'h40E0 | 16'(k << 11));
        end
        $display("test faults done");
        wr(2'h1, 16'h04C0);
        achk("sense idle", 1'b0);
        conv(hi(1));
        achk("sense active", 1'b1);
        conv(16'h1000);
        $display("test sense done");
        wr(2'h1, 16'h02C0);
        conv(16'h1800);
        conv(hi(1));
        achk("int set", 1'b0);
        conv(16'h1800);
        achk("int hold", 1'b0);
        rchk("reading", 2'h0, 16'h1800);
        achk("int read clr", 1'b1);
        conv(hi(1));
        achk("int high ignored", 1'b1);
        conv(lo());
        achk("int low", 1'b0);
        wr(2'h1, 16'h03C0);
        achk("sleep clr", 1'b1);
        $display("test interrupt done");
        n = 0;
        for (int i = 0; i < 300; i++) begin
            cyc(1);
            if (conv_start_q === 1'b1) n++;
        end
        chk("sleep starts", 16'h0, 16'(n));
        chk("deep sleep", 16'h1, {15'h0, deep_sleep_q});
        rchk("sleep cfg", 2'h1, 16'h43E0);
        slow = 1'b1;
        wr(2'h1, 16'h83C0);
        rchk("shot busy", 2'h1, 16'hC3E0);
        conv(16'h1800);
        rchk("shot done", 2'h1, 16'h43E0);
        slow = 1'b0;
        wr(2'h1, 16'h00C0);
        wst();
        chk("wake start", 16'h1, 16'(n < 4));
        $display("test sleep done");
        for (int r = 0; r < 4; r++) begin
            wr(2'h1, 16'(r << 6));
            wst();
            wst();
            wst();
            chk("period", 16'(per[r]), 16'(n));
        end
        $display("test rates done");
        final_report();
    end
    // watchdog
    initial begin
        #(25 * 40000);
        n_mismatch++;
        final_report();
    end
endmodule : tb
`default_nettype wire
